/* hdl/tcr_timer2.sv */
// Timer two: 16-bit timer/counter with capture, auto-reload and baud.
// Assumes an APB master on pclk and pins synchronous to pclk.
//
// Contract
// [R1] 16-bit count of two bytes, timer or event counter by source select.
// [R2] Timer mode adds one each machine cycle of twelve clocks.
// [R3] Off, baud, auto-reload or capture chosen by run and select bits.
// [R4] Counter samples count pin once per cycle; high then low counts.
// [R5] Counted edge shows in count at S3P1 of the following cycle.
// [R6] Count pin levels must be held at least one machine cycle.
// [R7] Capture mode without trigger enable is plain timer, overflow flag.
// [R8] Capture with trigger: falling trigger copies count, sets event flag.
// [R9] Reset clears down count enable, so reload mode counts up.
// [R10] Down enable: trigger pin level picks up or down counting.
// [R11] Interrupt request is OR of overflow and event flags; here each flag is first gated by its mask bit.
// [R12] Flags stay set until software clears them itself.
// [R13] Timer overflow flag is set at S2P2 of the overflow cycle.
// [R14] Trigger pin triggers and steers direction; count pin is the source.
// [R15] Reload mode loads count from reload on overflow or trigger edge; here a trigger edge reloads only while down count enable is clear.
// [R16] Down count wraps to FFFF at reload value; baud exports overflow.
//
// Design decisions made here: the register addresses, the APB slave port and the interrupt mask register.
`timescale 1ns/1ps
module tcr_timer2 (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic [tcr_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tcr_pkg::DATA_W-1:0]  pwdata,
  output      logic [tcr_pkg::DATA_W-1:0]  prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  // Pins
  input  wire logic                        external_count_input,
  input  wire logic                        trigger_direction_input,
  // Events
  output      logic                        timer_irq,
  output      logic                        baud_clock_pulse
);
  import tcr_pkg::*;

  typedef struct packed {
    logic [15:0]       count;
    logic [15:0]       reload;
    logic              run;
    logic              cnt_src;
    logic              cap_sel;
    logic              exen;
    logic              rclk;
    logic              transmit_clock_select;
    logic              down_count_enable;
    logic              ovf;
    logic              exf;
    logic [1:0]        mask;
    logic              cnt_pend;
    logic              baud_pulse;
    logic [DATA_W-1:0] rdata;
    logic              slverr;
  } tcr_state_t;

  tcr_state_t        st_ff;
  tcr_state_t        nxt_st;
  tcr_mode_t         mode;
  logic [3:0]        phase;
  logic              sample_en;
  logic              cnt_fall;
  logic              trig_fall;
  logic              trig_level;
  logic              count_down;
  logic              tick;
  logic              wrap;
  logic              setup;
  logic              wr_en;
  logic              hit;
  logic [DATA_W-1:0] rd_word;
  logic              ovf_evt;
  logic              exf_evt;

  // ********************************************************
  // Machine-cycle timing and pin sampling
  // ********************************************************
  tcr_phase_gen #(
    .PHASES (OSC_PER_MC)
  ) u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .phase   (phase)
  );

  // [R4] sample at S5P2
  assign sample_en = (phase == P_S5P2);

  // [R14] count pin is the event source
  tcr_edge_sampler u_cnt_pin (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (sample_en),
    .din       (external_count_input),
    .level     (),
    .fall      (cnt_fall)
  );

  // [R14] trigger pin gives edges and direction
  tcr_edge_sampler u_trig_pin (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (sample_en),
    .din       (trigger_direction_input),
    .level     (trig_level),
    .fall      (trig_fall)
  );

  // ********************************************************
  // Mode and count step
  // ********************************************************
  // [R3] mode decode
  always_comb begin
    if (!st_ff.run) begin
      mode = MODE_OFF;
    end else if (st_ff.rclk | st_ff.transmit_clock_select) begin
      mode = MODE_BAUD;
    end else if (st_ff.cap_sel) begin
      mode = MODE_CAPTURE;
    end else begin
      mode = MODE_RELOAD;
    end
  end

  // [R10] direction from trigger level
  assign count_down = (mode == MODE_RELOAD) & st_ff.down_count_enable & ~trig_level;

  // [R2] timer steps at S2P2, counter at S3P1 of the next cycle
  assign tick = (mode != MODE_OFF) &
                (st_ff.cnt_src ? (st_ff.cnt_pend & (phase == P_S3P1))
                               : (phase == P_S2P2));

  // [R16] down count wraps at the reload value
  assign wrap = count_down ? (st_ff.count == st_ff.reload)
                           : (st_ff.count == COUNT_TOP);

  // ********************************************************
  // APB decode
  // ********************************************************
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite;

  always_comb begin
    hit     = 1'b1;
    rd_word = '0;
    case (paddr)
      OFS_CTRL: begin
        rd_word[CTRL_RUN]  = st_ff.run;
        rd_word[CTRL_SRC]  = st_ff.cnt_src;
        rd_word[CTRL_CAP]  = st_ff.cap_sel;
        rd_word[CTRL_EXEN] = st_ff.exen;
        rd_word[CTRL_RCLK] = st_ff.rclk;
        rd_word[CTRL_TRANSMIT_CLOCK_SELECT] = st_ff.transmit_clock_select;
      end
      OFS_MODE:   rd_word[TMOD_DOWN_COUNT_ENABLE] = st_ff.down_count_enable;
      OFS_COUNT:  rd_word[15:0] = st_ff.count;
      OFS_RELOAD: rd_word[15:0] = st_ff.reload;
      OFS_STATUS: begin
        rd_word[ST_OVF] = st_ff.ovf;
        rd_word[ST_EXF] = st_ff.exf;
      end
      OFS_MASK:   rd_word[1:0] = st_ff.mask;
      default:    hit = 1'b0;
    endcase
  end

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    nxt_st            = st_ff;
    nxt_st.baud_pulse = 1'b0;
    ovf_evt           = 1'b0;
    exf_evt           = 1'b0;

    // [R5] a counted edge waits for S3P1
    if (mode == MODE_OFF) begin
      nxt_st.cnt_pend = 1'b0;
    end else if (cnt_fall && st_ff.cnt_src) begin
      nxt_st.cnt_pend = 1'b1;
    end else if (tick) begin
      nxt_st.cnt_pend = 1'b0;
    end

    // [R1] 16-bit step
    if (tick) begin
      if (wrap) begin
        if (count_down) begin
          nxt_st.count = COUNT_TOP;
        end else if (mode == MODE_CAPTURE) begin
          // [R7] capture mode rolls over to zero
          nxt_st.count = COUNT_RST;
        end else begin
          // [R15] reload on overflow
          nxt_st.count = st_ff.reload;
        end
        // [R16] baud overflow leaves the flag alone
        if (mode == MODE_BAUD) begin
          nxt_st.baud_pulse = 1'b1;
        end else begin
          // [R13] flag set with the step
          ovf_evt = 1'b1;
        end
      end else if (count_down) begin
        nxt_st.count = st_ff.count - COUNT_ONE;
      end else begin
        nxt_st.count = st_ff.count + COUNT_ONE;
      end
    end

    // Trigger edges land at phase 10, never on a step phase
    if (trig_fall && st_ff.exen && mode != MODE_OFF) begin
      exf_evt = 1'b1;
      if (mode == MODE_CAPTURE) begin
        // [R8] capture count into reload
        nxt_st.reload = st_ff.count;
      end else if (mode == MODE_RELOAD && !st_ff.down_count_enable) begin
        // [R15] trigger reload
        nxt_st.count = st_ff.reload;
      end
    end

    if (setup) begin
      nxt_st.rdata  = rd_word;
      nxt_st.slverr = ~hit;
    end

    // Software writes win over a count step in the same cycle
    if (wr_en) begin
      case (paddr)
        OFS_CTRL: begin
          nxt_st.run     = pwdata[CTRL_RUN];
          nxt_st.cnt_src = pwdata[CTRL_SRC];
          nxt_st.cap_sel = pwdata[CTRL_CAP];
          nxt_st.exen    = pwdata[CTRL_EXEN];
          nxt_st.rclk    = pwdata[CTRL_RCLK];
          nxt_st.transmit_clock_select    = pwdata[CTRL_TRANSMIT_CLOCK_SELECT];
        end
        OFS_MODE:   nxt_st.down_count_enable   = pwdata[TMOD_DOWN_COUNT_ENABLE];
        OFS_COUNT:  nxt_st.count  = pwdata[15:0];
        OFS_RELOAD: nxt_st.reload = pwdata[15:0];
        OFS_MASK:   nxt_st.mask   = pwdata[1:0];
        default:    nxt_st.mask   = st_ff.mask;
      endcase
    end

    // [R12] only software clears; a new event beats the clear
    nxt_st.ovf = ovf_evt | (st_ff.ovf &
                 ~(wr_en && paddr == OFS_STATUS && pwdata[ST_OVF]));
    nxt_st.exf = exf_evt | (st_ff.exf &
                 ~(wr_en && paddr == OFS_STATUS && pwdata[ST_EXF]));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff      <= '0;
      st_ff.mask <= MASK_RST;
      // [R9] count up after reset
      st_ff.down_count_enable <= DOWN_COUNT_ENABLE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign prdata  = st_ff.rdata;
  assign pready  = 1'b1;
  assign pslverr = st_ff.slverr & psel & penable;

  // [R11] OR of both flags, gated by mask
  assign timer_irq = |({st_ff.exf, st_ff.ovf} & st_ff.mask);
  assign baud_clock_pulse = st_ff.baud_pulse;

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cnt_fall;
    st_ff.cnt_src && mode != MODE_OFF && cnt_fall;
  endsequence

  sequence s_cnt_step;
    st_ff.cnt_src && mode != MODE_OFF && st_ff.cnt_pend &&
    phase == P_S3P1 && !count_down && !wrap && !wr_en;
  endsequence

  property p_tmr_step;
    (!st_ff.cnt_src && mode != MODE_OFF && phase == P_S2P2 &&
     !count_down && !wrap && !wr_en)
      |=> st_ff.count == $past(st_ff.count) + COUNT_ONE;
  endproperty
  a_tmr_step: assert property (p_tmr_step) // [R2]
    else $error("timer did not step at S2P2");

  property p_off_hold;
    (mode == MODE_OFF && !wr_en) |=> $stable(st_ff.count);
  endproperty
  a_off_hold: assert property (p_off_hold) // [R3]
    else $error("count moved while off");

  property p_cnt_pend;
    s_cnt_fall |-> ##[1:12] (phase == P_S3P1 && st_ff.cnt_pend);
  endproperty
  a_cnt_pend: assert property (p_cnt_pend) // [R4]
    else $error("counted edge not held to S3P1");

  property p_cnt_step;
    s_cnt_step |=> st_ff.count == $past(st_ff.count) + COUNT_ONE;
  endproperty
  a_cnt_step: assert property (p_cnt_step) // [R5]
    else $error("counter did not step at S3P1");

  property p_capture;
    (trig_fall && st_ff.exen && mode == MODE_CAPTURE && !wr_en)
      |=> st_ff.reload == $past(st_ff.count) && st_ff.exf;
  endproperty
  a_capture: assert property (p_capture) // [R8]
    else $error("capture missed");

  property p_down_count_enable_rst;
    !$past(presetn) |-> !st_ff.down_count_enable;
  endproperty
  a_down_count_enable_rst: assert property (p_down_count_enable_rst) // [R9]
    else $error("down enable not cleared by reset");

  property p_down_step;
    (tick && count_down && !wrap && !wr_en)
      |=> st_ff.count == $past(st_ff.count) - COUNT_ONE;
  endproperty
  a_down_step: assert property (p_down_step) // [R10]
    else $error("down count did not decrement");

  property p_irq;
    (st_ff.ovf && st_ff.mask[ST_OVF]) || (st_ff.exf && st_ff.mask[ST_EXF])
      |-> timer_irq;
  endproperty
  a_irq: assert property (p_irq) // [R11]
    else $error("flag set but no interrupt");

  property p_flag_keep;
    (st_ff.ovf && !(wr_en && paddr == OFS_STATUS)) |=> st_ff.ovf;
  endproperty
  a_flag_keep: assert property (p_flag_keep) // [R12]
    else $error("overflow flag cleared by hardware");

  property p_ovf_phase;
    ($rose(st_ff.ovf) && !$past(st_ff.cnt_src)) |-> $past(phase) == P_S2P2;
  endproperty
  a_ovf_phase: assert property (p_ovf_phase) // [R13]
    else $error("timer overflow flag not set at S2P2");

  property p_reload;
    (tick && wrap && mode == MODE_RELOAD && !count_down && !wr_en)
      |=> st_ff.count == $past(st_ff.reload) && st_ff.ovf;
  endproperty
  a_reload: assert property (p_reload) // [R15]
    else $error("auto-reload on overflow missed");

  property p_baud;
    (tick && wrap && mode == MODE_BAUD)
      |=> baud_clock_pulse ##1 !baud_clock_pulse;
  endproperty
  a_baud: assert property (p_baud) // [R16]
    else $error("baud overflow pulse wrong");

endmodule // tcr_timer2

/* hdl/tcr_pkg.sv */
// Constants and types shared by the timer two block.
// Assumes one 40 MHz clock that also stands for the oscillator.
package tcr_pkg;

  // ********************************************************
  // Bus shape
  // ********************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // ********************************************************
  // Register byte offsets
  // ********************************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_COUNT  = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_SRC  = 1;
  localparam int CTRL_CAP  = 2;
  localparam int CTRL_EXEN = 3;
  localparam int CTRL_RCLK = 4;
  localparam int CTRL_TRANSMIT_CLOCK_SELECT = 5;
  localparam int TMOD_DOWN_COUNT_ENABLE = 0;
  localparam int ST_OVF    = 0;
  localparam int ST_EXF    = 1;

  // ********************************************************
  // Reset values and count constants
  // ********************************************************
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] COUNT_TOP  = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam logic [1:0]  MASK_RST   = 2'h3;
  localparam logic        DOWN_COUNT_ENABLE_RST   = 1'b0;

  // ********************************************************
  // Timing: one machine cycle is twelve clock periods
  // ********************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_PER_MC    = 12;
  localparam logic [3:0] P_S2P2 = 4'h3;
  localparam logic [3:0] P_S3P1 = 4'h4;
  localparam logic [3:0] P_S5P2 = 4'h9;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_RELOAD,
    MODE_CAPTURE,
    MODE_BAUD
  } tcr_mode_t;

endpackage

/* hdl/tcr_phase_gen.sv */
// Machine-cycle phase counter for the timer two block.
// Assumes pclk is the oscillator; phase 0 is the first half of state 1.
`timescale 1ns/1ps
module tcr_phase_gen #(
  parameter int PHASES = tcr_pkg::OSC_PER_MC
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Phase within the machine cycle
  output      logic [3:0] phase
);
  import tcr_pkg::*;

  typedef struct packed {
    logic [3:0] phase;
  } tcr_pg_state_t;

  tcr_pg_state_t st_ff;
  tcr_pg_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (st_ff.phase == 4'(PHASES - 1)) begin
      nxt_st.phase = 4'h0;
    end else begin
      nxt_st.phase = st_ff.phase + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign phase = st_ff.phase;

endmodule // tcr_phase_gen

/* hdl/tcr_edge_sampler.sv */
// Once-per-machine-cycle pin sampler with falling-edge detect.
// Assumes din is synchronous to pclk and sample_en is a one-cycle strobe.
`timescale 1ns/1ps
module tcr_edge_sampler (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Sampling
  input  wire logic sample_en,
  input  wire logic din,
  // Results
  output      logic level,
  output      logic fall
);
  import tcr_pkg::*;

  typedef struct packed {
    logic level;
    logic fall;
  } tcr_es_state_t;

  tcr_es_state_t st_ff;
  tcr_es_state_t nxt_st;

  // Reset sample is low so no false edge follows reset
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.fall = 1'b0;
    if (sample_en) begin
      nxt_st.level = din;
      nxt_st.fall  = st_ff.level & ~din;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.level;
  assign fall  = st_ff.fall;

endmodule // tcr_edge_sampler

/* verif/tcr_pin_source.sv */
// Model of the sources that drive the count and trigger pins.
// Assumes pclk from the bench; both pins idle high like pulled-up pins.
`timescale 1ns/1ps
module tcr_pin_source (
  // Clock
  input  wire logic pclk,
  // Pins
  output      logic count_pin,
  output      logic trig_pin
);
  initial begin
    count_pin = 1'b1;
    trig_pin  = 1'b1;
  end

  task automatic hold_trig(input logic lvl, input int h);
    trig_pin <= lvl;
    repeat (h) @(posedge pclk);
  endtask

  // Each level held h cycles
  // Callers keep h at twelve or more, or a level may never be sampled
  task automatic pulses(input int n, input int h);
    repeat (n) begin
      @(posedge pclk);
      count_pin <= 1'b0;
      repeat (h) @(posedge pclk);
      count_pin <= 1'b1;
      repeat (h - 1) @(posedge pclk);
    end
  endtask
endmodule // tcr_pin_source

/* verif/tcr_timer2_tb.sv */
// Self-checking bench for the timer two block with a counting model.
// Assumes the APB slave answers in the access phase and one 40 MHz clock.
`timescale 1ns/1ps
module tcr_timer2_tb;
  import tcr_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic              pclk    = 1'b0;
  logic              presetn = 1'b0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = 8'h00;
  logic [DATA_W-1:0] pwdata  = 32'h00000000;
  logic [DATA_W-1:0] prdata, rd;
  logic              pready, pslverr, timer_irq, baud_clock_pulse;
  logic              err;
  wire logic         cnt_pin, trg_pin;
  logic [31:0]       seed    = 32'hC1FA8492;
  int                num_errors, tests_run, cyc, n_pulse, n_base;
  int                m_cnt, m_rel, m_ovf, m_pul, h;

  always #12.5 pclk = ~pclk;

  tcr_timer2 dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(cnt_pin), .trigger_direction_input(trg_pin),
    .timer_irq(timer_irq), .baud_clock_pulse(baud_clock_pulse));

  tcr_pin_source src (.pclk(pclk), .count_pin(cnt_pin), .trig_pin(trg_pin));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Read data and error are taken at the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input int e, input string nm);
    apb(1'b0, a, 32'h00000000);
    chk(nm, e, rd);
  endtask

  task automatic irq_chk(input logic e);
    @(negedge pclk);
    chk("irq", e, timer_irq);
  endtask

  // Model: one step per machine cycle; mode 0 capture, 1 reload, 2 baud
  task automatic model(input int n, input int mode, input bit down);
    repeat (n) begin
      if (down) begin
        if (m_cnt == m_rel) begin
          m_cnt = 65535;
          m_ovf = 1;
        end else m_cnt--;
      end else if (m_cnt == 65535) begin
        m_cnt = (mode == 0) ? 0 : m_rel;
        if (mode == 2) m_pul++;
        else m_ovf = 1;
      end else m_cnt++;
    end
  endtask

  // Run for n machine cycles: 12n edges between the two CTRL writes
  task automatic run(input string nm, input int ctl, input int c,
                     input int r, input int n, input int mode, input bit dn);
    wr(OFS_STATUS, 3);
    wr(OFS_RELOAD, r);
    wr(OFS_COUNT, c);
    m_cnt = c;
    m_rel = r;
    m_ovf = 0;
    m_pul = 0;
    n_base = n_pulse;
    wr(OFS_CTRL, ctl);
    repeat (12 * n - 3) @(posedge pclk);
    wr(OFS_CTRL, 0);
    model((ctl & 1) ? n : 0, mode, dn);
    rchk(OFS_COUNT, m_cnt, "count");
    rchk(OFS_STATUS, m_ovf, "status");
    chk("baud pulses", m_pul, n_pulse - n_base);
    $display("test %s done", nm);
  endtask

  task automatic trig_fall;
    src.hold_trig(1'b1, 24);
    src.hold_trig(1'b0, 24);
  endtask

  always @(posedge pclk) begin
    if (baud_clock_pulse === 1'b1) n_pulse++;
  end

  // Whole run is near 2600 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_CTRL, 0, "ctrl");
    rchk(OFS_MODE, 0, "down enable");
    rchk(OFS_COUNT, 0, "count");
    rchk(OFS_RELOAD, 0, "reload");
    rchk(OFS_STATUS, 0, "status");
    rchk(OFS_MASK, 3, "mask");
    rchk(8'h18, 0, "unmapped data");
    chk("unmapped error", 1, err);
    wr(8'h18, 32'hFFFFFFFF);
    rchk(OFS_MASK, 3, "mask after unmapped write");
    $display("test reset done");
    run("timer", 6'h05, 0, 0, 20, 0, 0);
    run("off", 6'h04, 16'h0100, 0, 20, 0, 0);
    run("wrap", 6'h05, 16'hFFF0, 0, 20, 0, 0);
    irq_chk(1'b1);
    wr(OFS_MASK, 0);
    irq_chk(1'b0);
    wr(OFS_MASK, 1);
    irq_chk(1'b1);
    wr(OFS_STATUS, 1);
    irq_chk(1'b0);
    wr(OFS_MASK, 3);
    run("reload", 6'h01, 16'hFFFE, 16'hFFF8, 20, 1, 0);
    wr(OFS_MODE, 1);
    src.hold_trig(1'b0, 24);
    run("down", 6'h01, 16'h0012, 16'h0010, 20, 1, 1);
    src.hold_trig(1'b1, 24);
    run("up down_count_enable", 6'h01, 16'hFFFE, 16'hFFF8, 20, 1, 0);
    wr(OFS_MODE, 0);
    for (int b = 4; b < 6; b++) begin
      run("baud", (1 << b) | 1, 16'hFFFE, 16'hFFFC, 20, 2, 0);
    end
    seed = lfsr(seed);
    h = 12 + seed[3:0];
    wr(OFS_COUNT, 0);
    wr(OFS_CTRL, 6'h07);
    src.pulses(5, h);
    repeat (40) @(posedge pclk);
    wr(OFS_CTRL, 0);
    rchk(OFS_COUNT, 5, "event count");
    $display("test counter done");
    seed = lfsr(seed);
    wr(OFS_COUNT, seed[15:0]);
    wr(OFS_STATUS, 3);
    wr(OFS_CTRL, 6'h0F);
    trig_fall();
    wr(OFS_CTRL, 0);
    rchk(OFS_RELOAD, seed[15:0], "captured");
    rchk(OFS_STATUS, 2, "event flag");
    irq_chk(1'b1);
    $display("test capture done");
    seed = lfsr(seed);
    wr(OFS_STATUS, 3);
    wr(OFS_COUNT, 0);
    wr(OFS_RELOAD, seed[15:0]);
    wr(OFS_CTRL, 6'h0B);
    trig_fall();
    wr(OFS_CTRL, 0);
    rchk(OFS_COUNT, seed[15:0], "reloaded");
    rchk(OFS_STATUS, 2, "event flag");
    src.hold_trig(1'b1, 24);
    $display("test trigger reload done");
    wr(OFS_STATUS, 3);
    wr(OFS_COUNT, 0);
    wr(OFS_CTRL, 6'h1B);
    trig_fall();
    wr(OFS_CTRL, 0);
    rchk(OFS_COUNT, 0, "baud count");
    rchk(OFS_STATUS, 2, "baud event flag");
    $display("test baud trigger done");
    wr(OFS_MODE, 1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFS_MODE, 0, "down enable after reset");
    rchk(OFS_COUNT, 0, "count after reset");
    $display("test mid reset done");
    end_of_test();
  end
endmodule // tcr_timer2_tb
